// ==== src/uart_pkg.sv ====
package uart_pkg;

	// Bus address width (byte address)
	localparam int ADDR_W = 10;

	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_STATUS = 8'h50;
	localparam logic [7:0] IDX_DATA   = 8'h51;
	localparam logic [7:0] IDX_BAUD   = 8'h52;
	localparam logic [7:0] IDX_CTRL1  = 8'h53;
	localparam logic [7:0] IDX_CTRL2  = 8'h54;
	localparam logic [7:0] IDX_RXFINE = 8'h55;
	localparam logic [7:0] IDX_TXFINE = 8'h57;

	// Reset values
	localparam logic [7:0] STATUS_RST = 8'hc0;
	localparam logic [7:0] CTRL1_RST  = 8'h00;
	localparam logic [7:0] CTRL2_RST  = 8'h00;
	localparam logic [7:0] BAUD_RST   = 8'h00;
	localparam logic [7:0] FINE_RST   = 8'h00;

	// Status bit positions
	localparam int SR_TX_BUFFER_EMPTY_FLAG = 7;
	localparam int SR_TC   = 6;
	localparam int SR_RX_FULL_FLAG = 5;
	localparam int SR_IDLE = 4;
	localparam int SR_OVR  = 3;
	localparam int SR_NF   = 2;
	localparam int SR_FE   = 1;

	// Control one bit positions
	localparam int C1_R8   = 7;
	localparam int C1_T8   = 6;
	localparam int C1_M    = 4;
	localparam int C1_WAKE = 3;

	// Control two bit positions
	localparam int C2_TIE  = 7;
	localparam int C2_TX_DONE_IRQ_EN = 6;
	localparam int C2_RIE  = 5;
	localparam int C2_IDLE_IRQ_EN = 4;
	localparam int C2_TE   = 3;
	localparam int C2_RE   = 2;
	localparam int C2_RWU  = 1;
	localparam int C2_SBK  = 0;

	// Baud select field positions
	localparam int BR_PR_LSB = 6;
	localparam int BR_TX_LSB = 3;
	localparam int BR_RX_LSB = 0;

	// Base scaling factors and the 32/16 ratio
	localparam logic [11:0] PR_F0    = 12'h001;
	localparam logic [11:0] PR_F1    = 12'h003;
	localparam logic [11:0] PR_F2    = 12'h004;
	localparam logic [11:0] PR_F3    = 12'h00d;
	localparam logic [11:0] PRE_MULT = 12'h002;

	// Oversampling: ticks per bit, majority window
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] VOTE_LO  = 4'h7;
	localparam logic [3:0] VOTE_HI  = 4'h9;

	// Frame length in bit times
	localparam logic [3:0] FLEN8 = 4'ha;
	localparam logic [3:0] FLEN9 = 4'hb;

	// Receiver and transmitter states
	typedef enum logic [2:0] {
		RX_OFF  = 3'b001,
		RX_HUNT = 3'b010,
		RX_DATA = 3'b100
	} rx_state_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} tx_state_t;

endpackage

// ==== src/uart_regs.sv ====
`timescale 1ns/10ps
`default_nettype none

module uart_regs
(
	// Clock and reset
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_b_i,
	// Avalon-MM slave
	input  wire logic [uart_pkg::ADDR_W-1:0] avs_address_i,
	input  wire logic                       avs_read_i,
	input  wire logic                       avs_write_i,
	input  wire logic [31:0]                avs_writedata_i,
	input  wire logic [3:0]                 avs_byteenable_i,
	output logic      [31:0]                avs_readdata_o,
	output logic                            avs_waitrequest_o,
	// Serial pins
	input  wire logic                       rx_i,
	output logic                            tx_o,
	output logic                            tx_oe_o,
	// Interrupt request
	output logic                            irq_o
);
	import uart_pkg::*;

	// Whole module state
	typedef struct packed {
		logic        wait_b;   // Waitrequest
		logic [7:0]  rdata;    // Read data
		logic        sr_seen;  // Status access seen
		logic [7:0]  tx_hold;  // Transmit holding
		logic        tx_buffer_empty_flag;     // Holding empty
		logic        tc;       // Transmit done
		logic        rx_full_flag;     // Receive full
		logic        idle;     // Idle line
		logic        ovr;      // Overrun
		logic        nf;       // Noise
		logic        fe;       // Framing error
		logic [7:0]  rx_hold;  // Receive holding
		logic        r8;       // Ninth bit in
		logic        t8;       // Ninth bit out
		logic        m;        // Nine-bit mode
		logic        wake;     // Wake method
		logic        tx_empty_irq_en;      // Enables
		logic        tx_done_irq_en;
		logic        rx_irq_en;
		logic        idle_irq_en;
		logic        tx_on;
		logic        rx_on;
		logic        mute;
		logic        send_break_ctl;
		logic [7:0]  baud;     // Baud select
		logic [7:0]  rx_fine;  // Fine dividers
		logic [7:0]  tx_fine;
		logic        pre_pend; // Preamble owed
		logic        brk_pend; // Break owed
		tx_state_t   tx_st;
		logic [11:0] tx_div;
		logic [3:0]  tx_sub;
		logic [3:0]  tx_bits;
		logic [10:0] tx_shf;
		logic        tx_line;
		rx_state_t   rx_st;
		logic        rx_s1;    // Synchroniser
		logic        rx_s2;
		logic [11:0] rx_div;
		logic [3:0]  rx_sub;
		logic [3:0]  rx_bits;
		logic [8:0]  rx_shf;
		logic [1:0]  vote;
		logic        noise;
		logic [3:0]  idle_bits;
		logic        idle_done;
		logic        idle_arm;
		logic        irq;
	} state_t;

	state_t st_q;    // Registered state
	state_t st_d;    // Next state

	// Event strobes for checking
	logic tx_load;   // Data moved to shift
	logic tx_done;   // Frame finished
	logic rx_load;   // Word to holding
	logic ovr_evt;   // Word lost to overrun
	logic idle_evt;  // Idle line seen

	// Divisor per direction: fine value or 2*scale*2^code
	function automatic logic [11:0] div_of(input logic [7:0] fine,
		input logic [1:0] pr, input logic [2:0] sel);
		logic [11:0] base;
		base = PR_F0;
		unique case (pr)
			2'h0: base = PR_F0;
			2'h1: base = PR_F1;
			2'h2: base = PR_F2;
			2'h3: base = PR_F3;
		endcase
		if (fine != 8'h00)
			div_of = {4'h0, fine};
		else
			div_of = 12'(PRE_MULT * base) << sel;
	endfunction

	logic [11:0] tx_lim;  // Transmit tick divisor
	logic [11:0] rx_lim;  // Receive tick divisor
	logic [3:0]  flen;    // Frame bit times

	// Rate selection
	always_comb
	begin
		tx_lim = div_of(st_q.tx_fine, st_q.baud[BR_PR_LSB+:2],
			st_q.baud[BR_TX_LSB+:3]);
		rx_lim = div_of(st_q.rx_fine, st_q.baud[BR_PR_LSB+:2],
			st_q.baud[BR_RX_LSB+:3]);
		flen = st_q.m ? FLEN9 : FLEN8;
	end

	// Next-state logic
	always_comb
	begin
		logic       req;
		logic       acc;
		logic       hit_w;
		logic       ttick;
		logic       rtick;
		logic       bitv;
		logic       msb;
		logic       take;
		logic [7:0] rd;
		logic [7:0] wd;
		req   = avs_read_i | avs_write_i;
		acc   = req & ~st_q.wait_b;
		hit_w = avs_write_i & avs_byteenable_i[0];
		ttick = 1'b0;
		rtick = 1'b0;
		bitv  = 1'b0;
		msb   = 1'b0;
		take  = 1'b0;
		rd    = 8'h00;
		wd    = avs_writedata_i[7:0];
		st_d  = st_q;
		tx_load  = 1'b0;
		tx_done  = 1'b0;
		rx_load  = 1'b0;
		ovr_evt  = 1'b0;
		idle_evt = 1'b0;

		// Read mux; unmapped reads return zero
		unique case (avs_address_i[ADDR_W-1:2])
			IDX_STATUS:
			begin
				rd[SR_TX_BUFFER_EMPTY_FLAG] = st_q.tx_buffer_empty_flag;
				rd[SR_TC]   = st_q.tc;
				rd[SR_RX_FULL_FLAG] = st_q.rx_full_flag;
				rd[SR_IDLE] = st_q.idle;
				rd[SR_OVR]  = st_q.ovr;
				rd[SR_NF]   = st_q.nf;
				rd[SR_FE]   = st_q.fe;
			end
			IDX_DATA:   rd = st_q.rx_hold;
			IDX_BAUD:   rd = st_q.baud;
			IDX_CTRL1:
			begin
				rd[C1_R8]   = st_q.r8;
				rd[C1_T8]   = st_q.t8;
				rd[C1_M]    = st_q.m;
				rd[C1_WAKE] = st_q.wake;
			end
			IDX_CTRL2:
				rd = {st_q.tx_empty_irq_en, st_q.tx_done_irq_en, st_q.rx_irq_en, st_q.idle_irq_en,
					st_q.tx_on, st_q.rx_on, st_q.mute, st_q.send_break_ctl};
			IDX_RXFINE: rd = st_q.rx_fine;
			IDX_TXFINE: rd = st_q.tx_fine;
			default:    rd = 8'h00;
		endcase

		// One wait cycle, then the access is taken
		st_d.wait_b = ~(req & st_q.wait_b);
		if (req & st_q.wait_b)
			st_d.rdata = avs_read_i ? rd : 8'h00;

		// Register side effects at the accepting edge
		if (acc)
		begin
			unique case (avs_address_i[ADDR_W-1:2])
				IDX_STATUS:
					st_d.sr_seen = 1'b1;
				IDX_DATA:
				begin
					st_d.sr_seen = 1'b0;
					if (avs_read_i & st_q.sr_seen)
					begin
						st_d.rx_full_flag = 1'b0;
						st_d.idle = 1'b0;
						st_d.ovr  = 1'b0;
						st_d.nf   = 1'b0;
						st_d.fe   = 1'b0;
					end
					if (hit_w)
					begin
						st_d.tx_hold = wd;
						if (st_q.sr_seen)
						begin
							st_d.tx_buffer_empty_flag = 1'b0;
							st_d.tc   = 1'b0;
						end
					end
				end
				IDX_BAUD:
					if (hit_w) st_d.baud = wd;
				IDX_CTRL1:
					if (hit_w)
					begin
						st_d.t8   = wd[C1_T8];
						st_d.m    = wd[C1_M];
						st_d.wake = wd[C1_WAKE];
					end
				IDX_CTRL2:
					if (hit_w)
					begin
						st_d.tx_empty_irq_en   = wd[C2_TIE];
						st_d.tx_done_irq_en  = wd[C2_TX_DONE_IRQ_EN];
						st_d.rx_irq_en   = wd[C2_RIE];
						st_d.idle_irq_en  = wd[C2_IDLE_IRQ_EN];
						st_d.tx_on = wd[C2_TE];
						st_d.rx_on = wd[C2_RE];
						st_d.mute  = wd[C2_RWU];
						st_d.send_break_ctl   = wd[C2_SBK];
						// Break on a rising break bit
						if (wd[C2_SBK] & ~st_q.send_break_ctl)
							st_d.brk_pend = 1'b1;
						// Enable dropped mid-frame owes a preamble
						if (~wd[C2_TE] & st_q.tx_on & (st_q.tx_st == TX_SEND))
							st_d.pre_pend = 1'b1;
					end
				IDX_RXFINE:
					if (hit_w) st_d.rx_fine = wd;
				IDX_TXFINE:
					if (hit_w) st_d.tx_fine = wd;
				default: ;
			endcase
		end

		// Transmit tick at 16 times the bit rate
		if (st_q.tx_div >= tx_lim - 12'h001)
		begin
			st_d.tx_div = 12'h000;
			ttick = 1'b1;
		end
		else
			st_d.tx_div = st_q.tx_div + 12'h001;

		// Transmitter
		unique case (st_q.tx_st)
			TX_IDLE:
			begin
				st_d.tx_line = 1'b1;
				if (st_q.tx_on)
				begin
					if (st_q.send_break_ctl | st_q.brk_pend)
					begin
						st_d.tx_shf   = 11'h000;
						st_d.brk_pend = 1'b0;
						st_d.tx_st    = TX_SEND;
					end
					else if (st_q.pre_pend)
					begin
						st_d.tx_shf   = 11'h7ff;
						st_d.pre_pend = 1'b0;
						st_d.tx_st    = TX_SEND;
					end
					else if (~st_q.tx_buffer_empty_flag)
					begin
						// Start bit in bit 0, data from its LSB
						st_d.tx_shf = {2'b11, st_q.tx_hold, 1'b0};
						if (st_q.m)
							st_d.tx_shf[9] = st_q.t8;
						st_d.tx_buffer_empty_flag  = 1'b1;
						st_d.tx_st = TX_SEND;
						tx_load    = 1'b1;
					end
					st_d.tx_bits = flen;
					st_d.tx_sub  = OVS_LAST;
				end
			end
			TX_SEND:
				if (ttick)
				begin
					st_d.tx_sub = st_q.tx_sub + 4'h1;
					if (st_q.tx_sub == OVS_LAST)
					begin
						if (st_q.tx_bits != 4'h0)
						begin
							st_d.tx_line = st_q.tx_shf[0];
							st_d.tx_shf  = {1'b1, st_q.tx_shf[10:1]};
							st_d.tx_bits = st_q.tx_bits - 4'h1;
						end
						else
						begin
							st_d.tx_line = 1'b1;
							st_d.tc      = 1'b1;
							st_d.tx_st   = TX_IDLE;
							tx_done      = 1'b1;
						end
					end
				end
			default: st_d.tx_st = TX_IDLE;
		endcase

		// Receive line synchroniser
		st_d.rx_s1 = rx_i;
		st_d.rx_s2 = st_q.rx_s1;

		// Receive tick at 16 times the bit rate
		if (st_q.rx_div >= rx_lim - 12'h001)
		begin
			st_d.rx_div = 12'h000;
			rtick = 1'b1;
		end
		else
			st_d.rx_div = st_q.rx_div + 12'h001;

		// Receiver
		unique case (st_q.rx_st)
			RX_OFF:
			begin
				st_d.idle_bits = 4'h0;
				st_d.idle_done = 1'b0;
				if (st_q.rx_on)
					st_d.rx_st = RX_HUNT;
			end
			RX_HUNT:
				if (~st_q.rx_on)
					st_d.rx_st = RX_OFF;
				else if (~st_q.rx_s2)
				begin
					// Start edge: sample this frame from tick zero
					st_d.rx_st     = RX_DATA;
					st_d.rx_sub    = 4'h0;
					st_d.rx_bits   = 4'h0;
					st_d.vote      = 2'h0;
					st_d.noise     = 1'b0;
					st_d.idle_bits = 4'h0;
					st_d.idle_done = 1'b0;
				end
				else if (rtick)
				begin
					// Count whole bit times of high line
					st_d.rx_sub = st_q.rx_sub + 4'h1;
					if ((st_q.rx_sub == OVS_LAST) & ~st_q.idle_done)
					begin
						st_d.idle_bits = st_q.idle_bits + 4'h1;
						if (st_q.idle_bits + 4'h1 == flen)
						begin
							st_d.idle_done = 1'b1;
							idle_evt       = 1'b1;
						end
					end
				end
			RX_DATA:
				if (~st_q.rx_on)
					st_d.rx_st = RX_OFF;
				else if (rtick)
				begin
					st_d.rx_sub = st_q.rx_sub + 4'h1;
					if ((st_q.rx_sub >= VOTE_LO) & (st_q.rx_sub <= VOTE_HI))
						st_d.vote = st_q.vote + {1'b0, st_q.rx_s2};
					if (st_q.rx_sub == OVS_LAST)
					begin
						// Majority of three; disagreement is noise
						bitv = st_q.vote[1];
						st_d.vote  = 2'h0;
						st_d.noise = st_q.noise |
							((st_q.vote != 2'h0) & (st_q.vote != 2'h3));
						st_d.rx_bits = st_q.rx_bits + 4'h1;
						if ((st_q.rx_bits == 4'h0) & bitv)
							st_d.rx_st = RX_HUNT;
						else if (st_q.rx_bits == flen - 4'h1)
						begin
							st_d.rx_st = RX_HUNT;
							msb  = st_q.m ? st_q.rx_shf[8] : st_q.rx_shf[7];
							take = ~st_q.mute;
							if (st_q.mute & st_q.wake & msb)
							begin
								st_d.mute = 1'b0;
								take      = 1'b1;
							end
							if (take & st_q.rx_full_flag)
							begin
								st_d.ovr = 1'b1;
								ovr_evt  = 1'b1;
							end
							else if (take)
							begin
								st_d.rx_hold  = st_q.rx_shf[7:0];
								if (st_q.m)
									st_d.r8 = st_q.rx_shf[8];
								st_d.rx_full_flag     = 1'b1;
								st_d.nf       = st_d.noise;
								st_d.fe       = ~bitv;
								st_d.idle_arm = 1'b1;
								rx_load       = 1'b1;
							end
						end
						else if (st_q.rx_bits != 4'h0)
							st_d.rx_shf[st_q.rx_bits - 4'h1] = bitv;
					end
				end
			default: st_d.rx_st = RX_OFF;
		endcase

		// Idle line: wakes a muted receiver when wake is clear, or flags once if not muted
		if (idle_evt)
		begin
			if (st_q.mute & ~st_q.wake)
				st_d.mute = 1'b0;
			else if (~st_q.mute & st_q.idle_arm)
			begin
				st_d.idle     = 1'b1;
				st_d.idle_arm = 1'b0;
			end
		end

		// Combined interrupt request
		st_d.irq = (st_q.tx_empty_irq_en & st_q.tx_buffer_empty_flag) | (st_q.tx_done_irq_en & st_q.tc) |
			(st_q.rx_irq_en & (st_q.ovr | st_q.rx_full_flag)) |
			(st_q.idle_irq_en & st_q.idle);
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_q          <= '0;
			st_q.wait_b   <= 1'b1;
			st_q.tx_buffer_empty_flag     <= STATUS_RST[SR_TX_BUFFER_EMPTY_FLAG];
			st_q.tc       <= STATUS_RST[SR_TC];
			st_q.m        <= CTRL1_RST[C1_M];
			st_q.tx_on    <= CTRL2_RST[C2_TE];
			st_q.baud     <= BAUD_RST;
			st_q.rx_fine  <= FINE_RST;
			st_q.tx_fine  <= FINE_RST;
			st_q.tx_st    <= TX_IDLE;
			st_q.tx_line  <= 1'b1;
			st_q.rx_st    <= RX_OFF;
			st_q.rx_s1    <= 1'b1;
			st_q.rx_s2    <= 1'b1;
			st_q.idle_arm <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from flops
	assign avs_readdata_o    = {24'h000000, st_q.rdata};
	assign avs_waitrequest_o = st_q.wait_b;
	assign tx_o              = st_q.tx_line;
	assign tx_oe_o           = st_q.tx_on;
	assign irq_o             = st_q.irq;

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	a_tx_no_load: assert property (tx_load |-> !st_q.tx_buffer_empty_flag)
		else $error("data moved while holding marked empty");
	a_tx_buffer_empty_flag_sets: assert property (tx_load |=> st_q.tx_buffer_empty_flag)
		else $error("empty flag not set after shift load");
	a_tc_sets: assert property (tx_done |=> st_q.tc && st_q.tx_line)
		else $error("done flag missing after frame");
	a_frame_len: assert property ($rose(st_q.tx_st == TX_SEND) |->
		st_q.tx_bits == ($past(st_q.m) ? 4'hb : 4'ha))
		else $error("wrong frame length");
	a_rx_word: assert property (rx_load |=> st_q.rx_full_flag &&
		st_q.rx_hold == $past(st_q.rx_shf[7:0]))
		else $error("received word not held");
	a_ovr_hold: assert property (ovr_evt |=> st_q.ovr &&
		$stable(st_q.rx_hold) && !$rose(st_q.fe))
		else $error("overrun corrupted holding or set framing");
	a_idle_once: assert property ($rose(st_q.idle) |->
		$past(st_q.idle_arm) && !st_q.idle_arm)
		else $error("idle flag set without arming");
	a_irq_map: assert property (##1 irq_o == $past((st_q.tx_empty_irq_en & st_q.tx_buffer_empty_flag) |
		(st_q.tx_done_irq_en & st_q.tc) | (st_q.rx_irq_en & (st_q.ovr | st_q.rx_full_flag)) |
		(st_q.idle_irq_en & st_q.idle)))
		else $error("interrupt output mismatch");
	a_bus_answer: assert property (((avs_read_i || avs_write_i) && avs_waitrequest_o) |=>
		!avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not after one wait cycle");
	a_wake_mark: assert property (((ovr_evt || rx_load) && st_q.mute) |=>
		!st_q.mute)
		else $error("address mark left receiver muted");

endmodule // uart_regs

`default_nettype wire

// ==== tb/serial_peer.sv ====
`timescale 1ns/10ps
`default_nettype none

// Far-side transceiver: sends frames to the block and captures its frames
module serial_peer
#(
	parameter int BIT_CYC = 32	// Clock cycles per bit
)
(
	// Clock
	input  wire logic       clk_sys_i,
	// Block pins
	input  wire logic       tx_i,
	input  wire logic       tx_oe_i,
	input  wire logic       nine_i,
	output logic            rx_o,
	// Last captured frame
	output logic [8:0]      word_o,
	output logic            stop_o,
	output int              count_o
);
	logic line;	// Pin level; pull-up while released
	int   k;	// Capture bit index

	assign line = tx_oe_i ? tx_i : 1'b1;

	// Idle line and empty capture at start
	initial
	begin
		rx_o = 1'b1;
		word_o = 9'h000;
		stop_o = 1'b1;
		count_o = 0;
	end

	// One frame, start low, data LSB first, then stop
	task automatic send(input logic [8:0] w, input logic nine, input logic stop);
		@(posedge clk_sys_i) rx_o <= 1'b0;
		repeat (BIT_CYC - 1) @(posedge clk_sys_i);
		for (int i = 0; i < (nine ? 9 : 8); i++)
		begin
			@(posedge clk_sys_i) rx_o <= w[i];
			repeat (BIT_CYC - 1) @(posedge clk_sys_i);
		end
		@(posedge clk_sys_i) rx_o <= stop;
		repeat (BIT_CYC - 1) @(posedge clk_sys_i);
		@(posedge clk_sys_i) rx_o <= 1'b1;
	endtask

	// Sample mid-bit after a falling start edge
	always @(posedge clk_sys_i)
	begin
		if (line === 1'b0)
		begin
			repeat (BIT_CYC / 2) @(posedge clk_sys_i);
			word_o[8] = 1'b0;
			for (k = 0; k < (nine_i ? 9 : 8); k++)
			begin
				repeat (BIT_CYC) @(posedge clk_sys_i);
				word_o[k] = line;
			end
			repeat (BIT_CYC) @(posedge clk_sys_i);
			stop_o = line;
			count_o++;
			// A break keeps the line low; wait for release
			while (line !== 1'b1) @(posedge clk_sys_i);
		end
	end
endmodule // serial_peer

`default_nettype wire

// ==== tb/tb_async_serial_regs_status.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_async_serial_regs_status;
	import uart_pkg::*;

	localparam int LIMIT = 40000;	// Cycle ceiling

	logic              clk_sys;	// 20 MHz clock
	logic              rst_b;	// Reset, active low
	logic [ADDR_W-1:0] avs_address;	// Bus address
	logic              avs_read;	// Read strobe
	logic              avs_write;	// Write strobe
	logic [31:0]       avs_writedata;	// Write data
	logic [31:0]       avs_readdata;	// Read data
	logic              avs_waitrequest;	// Slave wait
	logic              rx_line;	// Peer to block
	logic              tx_line;	// Block to peer
	logic              tx_oe;	// Block owns pin
	logic              irq;	// Interrupt request
	logic              nine_mode;	// Peer word length
	logic [8:0]        peer_word;	// Captured word
	logic              peer_stop;	// Captured stop bit
	int                peer_count;	// Frames captured
	logic [7:0]        s;	// Read scratch
	int                n;	// Frame count snapshot
	int                cycles;	// Run length
	int                num_errors;	// Mismatches
	int                compares;	// Comparisons

	// Device under test
	uart_regs uart_regs_inst (
		.clk_sys_i(clk_sys), .rst_b_i(rst_b), .avs_address_i(avs_address),
		.avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest), .rx_i(rx_line), .tx_o(tx_line),
		.tx_oe_o(tx_oe), .irq_o(irq)
	);

	// Far side of the serial link; fine divider 2 gives 32 cycles a bit
	serial_peer #(.BIT_CYC(32)) serial_peer_inst (
		.clk_sys_i(clk_sys), .tx_i(tx_line), .tx_oe_i(tx_oe), .nine_i(nine_mode),
		.rx_o(rx_line), .word_o(peer_word), .stop_o(peer_stop), .count_o(peer_count)
	);

	// Clock source
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Verdict and end of run
	task automatic report_and_stop();
		$display("compares %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Compare seen against expected
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// One bus access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge clk_sys);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h000000, wd};
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Register write
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] dummy;
		bus(1'b1, idx, d, dummy);
	endtask

	// Poll status until one flag is up
	task automatic wait_flag(input int b);
		do bus(1'b0, IDX_STATUS, 8'h00, s);
		while (s[b] !== 1'b1);
	endtask

	// Hang guard
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	// Main sequence
	initial
	begin
		cycles = 0;
		num_errors = 0;
		compares = 0;
		rst_b = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		nine_mode = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		check("tx_oe reset", tx_oe, 1'b0);
		bus(1'b0, IDX_STATUS, 8'h00, s); check("status reset", s, STATUS_RST);
		bus(1'b0, IDX_CTRL2, 8'h00, s); check("ctrl2 reset", s, CTRL2_RST);
		bus(1'b0, 8'h56, 8'h00, s); check("unmapped", s, 8'h00);
		// Coarse divisor set slow; fine dividers must replace it
		wr(IDX_BAUD, 8'hda);
		bus(1'b0, IDX_BAUD, 8'h00, s); check("baud", s, 8'hda);
		wr(IDX_RXFINE, 8'h02);
		wr(IDX_TXFINE, 8'h02);
		// Transmit, then a write without the arming read
		wr(IDX_CTRL2, 8'h08);
		bus(1'b0, IDX_STATUS, 8'h00, s); check("tx_oe on", tx_oe, 1'b1);
		n = peer_count;
		wr(IDX_DATA, 8'ha5);
		bus(1'b0, IDX_STATUS, 8'h00, s); check("load flags", s[7:6], 2'b10);
		bus(1'b0, IDX_DATA, 8'h00, s);
		wr(IDX_DATA, 8'h3c);
		while (peer_count == n) @(posedge clk_sys);
		check("tx word", peer_word, 9'h0a5);
		wait_flag(SR_TC); check("done flags", s[7:6], 2'b11);
		wr(IDX_DATA, 8'h5a);
		while (peer_count == n + 1) @(posedge clk_sys);
		check("reloaded word", peer_word, 9'h05a);
		// One break word after a set-then-clear pulse
		wr(IDX_CTRL2, 8'h09);
		wr(IDX_CTRL2, 8'h08);
		while (peer_count == n + 2) @(posedge clk_sys);
		check("break data", peer_word, 9'h000);
		check("break stop", peer_stop, 1'b0);
		// Empty interrupt enable and mask
		wr(IDX_CTRL2, 8'h88);
		bus(1'b0, IDX_STATUS, 8'h00, s); check("irq empty", irq, 1'b1);
		wr(IDX_CTRL2, 8'h08);
		bus(1'b0, IDX_STATUS, 8'h00, s); check("irq masked", irq, 1'b0);
		// Receive a clean word with receive interrupt on
		wr(IDX_CTRL2, 8'h2c);
		serial_peer_inst.send(9'h05a, 1'b0, 1'b1);
		wait_flag(SR_RX_FULL_FLAG); check("rx flags", s & 8'h2e, 8'h20);
		check("irq rx", irq, 1'b1);
		bus(1'b0, IDX_DATA, 8'h00, s); check("rx word", s, 8'h5a);
		bus(1'b0, IDX_STATUS, 8'h00, s); check("rx cleared", s[5], 1'b0);
		check("irq cleared", irq, 1'b0);
		// Overrun: second word lost, first kept
		serial_peer_inst.send(9'h011, 1'b0, 1'b1);
		serial_peer_inst.send(9'h022, 1'b0, 1'b0);
		wait_flag(SR_OVR); check("overrun flags", s & 8'h2a, 8'h28);
		bus(1'b0, IDX_DATA, 8'h00, s); check("kept word", s, 8'h11);
		// Framing error still transfers the word
		serial_peer_inst.send(9'h033, 1'b0, 1'b0);
		wait_flag(SR_RX_FULL_FLAG); check("framing", s[SR_FE], 1'b1);
		bus(1'b0, IDX_DATA, 8'h00, s); check("framed word", s, 8'h33);
		// Nine-bit words both ways
		wr(IDX_CTRL1, 8'h50);
		nine_mode <= 1'b1;
		n = peer_count;
		bus(1'b0, IDX_STATUS, 8'h00, s);
		wr(IDX_DATA, 8'h3c);
		while (peer_count == n) @(posedge clk_sys);
		check("tx nine", peer_word, 9'h13c);
		serial_peer_inst.send(9'h1c3, 1'b1, 1'b1);
		wait_flag(SR_RX_FULL_FLAG);
		bus(1'b0, IDX_CTRL1, 8'h00, s); check("rx ninth", s[C1_R8], 1'b1);
		bus(1'b0, IDX_DATA, 8'h00, s); check("rx nine", s, 8'hc3);
		// Address-mark wake from mute
		wr(IDX_CTRL1, 8'h08);
		nine_mode <= 1'b0;
		wr(IDX_CTRL2, 8'h2e);
		serial_peer_inst.send(9'h005, 1'b0, 1'b1);
		bus(1'b0, IDX_STATUS, 8'h00, s); check("muted", s[SR_RX_FULL_FLAG], 1'b0);
		serial_peer_inst.send(9'h085, 1'b0, 1'b1);
		wait_flag(SR_RX_FULL_FLAG);
		bus(1'b0, IDX_CTRL2, 8'h00, s); check("mute off", s[C2_RWU], 1'b0);
		check("irq wake", irq, 1'b1);
		bus(1'b0, IDX_DATA, 8'h00, s); check("address", s, 8'h85);
		// Idle line after the word raises only the idle flag and its interrupt
		wr(IDX_CTRL2, 8'h1c);
		wait_flag(SR_IDLE); check("idle only", s & 8'h3e, 8'h10);
		check("irq idle", irq, 1'b1);
		report_and_stop();
	end
endmodule // tb_async_serial_regs_status

`default_nettype wire
